// ---- include/power_ok_pkg.sv ----
// constants and carriers for the power-ok and event flag block
// assumes a 100 MHz core clock and an 8-bit register port
package power_ok_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned HOLD_TIME_US   = 800;
    localparam int unsigned HOLD_CYCLES    =
        (HOLD_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_WIDTH     = 17;
    localparam int unsigned RAILS          = 4;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_FLAG_TOP   = 8'h00;
    localparam logic [7:0] ADDR_FLAG_RAIL  = 8'h01;
    localparam logic [7:0] ADDR_MASK_TOP   = 8'h02;
    localparam logic [7:0] ADDR_MASK_RAIL  = 8'h03;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_POK_CTRL1  = 8'h05;
    localparam logic [7:0] ADDR_POK_CTRL2  = 8'h06;
    localparam logic [7:0] ADDR_FAULT      = 8'h07;
    localparam logic [7:0] ADDR_COMMAND    = 8'h08;
    // ==========================================================
    // top flag, top mask and status bit positions
    localparam int unsigned TOP_OVERHEAT   = 0;
    localparam int unsigned TOP_OVERVOLT   = 1;
    localparam int unsigned TOP_POWER_OK   = 2;
    localparam int unsigned TOP_SYNC       = 3;
    localparam int unsigned TOP_MEASURE    = 4;
    localparam int unsigned TOP_RESET      = 5;
    localparam int unsigned STAT_RAIL_LSB  = 4;
    // rail mask: rise masks low nibble, fall masks high nibble
    localparam int unsigned FALL_LSB       = 4;
    // control register 1
    localparam int unsigned CTL_POLARITY   = 4;
    localparam int unsigned CTL_OPEN_DRAIN = 5;
    localparam int unsigned CTL_TWARN_SEL  = 6;
    // control register 2
    localparam int unsigned CTL_MODE       = 0;
    localparam int unsigned CTL_GATING     = 1;
    localparam int unsigned WINDOW_LSB     = 2;
    // command register
    localparam int unsigned CMD_SW_RESET   = 0;
    // ==========================================================
    // reset values
    localparam logic [7:0] MASK_TOP_RESET  = 8'h00;
    localparam logic [7:0] MASK_RAIL_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET     = 8'h0F;
    localparam logic [7:0] CTRL2_RESET     = 8'h00;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] writeData;
        logic       write;
        logic       read;
    } bus_req_type;

    typedef struct packed {
        logic             overheat;
        logic             overvoltage;
        logic             thermalWarning;
        logic             syncPresent;
        logic [RAILS-1:0] railValid;
        logic [RAILS-1:0] railOver;
    } monitor_type;
endpackage : power_ok_pkg

// ---- hdl/sticky_flag.sv ----
// one sticky event flag, set wins over every clear
// assumes set, clear and hold come from the core clock domain
`timescale 1ns/1ps
module sticky_flag #(
    parameter logic INIT = 1'b0
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // control
    input  wire logic set,
    input  wire logic clear,
    input  wire logic hold,
    input  wire logic wipe,
    // state
    output logic      flag
);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= INIT;
        end else if (set) begin
            flag <= 1'b1;
        end else if (wipe) begin
            flag <= 1'b0;
        end else if (clear && !hold) begin
            flag <= 1'b0;
        end
    end
endmodule : sticky_flag

// ---- hdl/power_ok_flags.sv ----
// power-ok pin logic and event flags of the regulator monitor
// assumes analog monitor levels arrive asynchronously; enables,
// voltage change pulses and measurement pulses are core-clocked
`timescale 1ns/1ps
module power_ok_flags
    import power_ok_pkg::*;
#(
    parameter int unsigned HOLD_COUNT = power_ok_pkg::HOLD_CYCLES
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    // register port
    input  wire power_ok_pkg::bus_req_type   busReq,
    output logic [7:0]                       readData,
    // analog monitors, asynchronous
    input  wire power_ok_pkg::monitor_type   monitor,
    // core-clocked events
    input  wire logic [power_ok_pkg::RAILS-1:0] railEnable,
    input  wire logic [power_ok_pkg::RAILS-1:0] railMoving,
    input  wire logic [power_ok_pkg::RAILS-1:0] voltageChange,
    input  wire logic                        clockDetectOn,
    input  wire logic                        measureDone,
    input  wire logic                        configDone,
    input  wire logic                        configResetMask,
    // outputs
    output logic                             interruptOut_n,
    output logic                             powerOkOut,
    output logic                             powerOkOe,
    output logic                             regulatorShutdown,
    output logic                             generalOutputLow
);
    // ==========================================================
    // synchronisers
    monitor_type monSync1;
    monitor_type monSync2;
    monitor_type monPrev;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            monSync1 <= '0;
            monSync2 <= '0;
            monPrev  <= '0;
        end else begin
            monSync1 <= monitor;
            monSync2 <= monSync1;
            monPrev  <= monSync2;
        end
    end

    // ==========================================================
    // register writes
    logic              softReset;
    logic [7:0]        maskTop;
    logic [7:0]        maskRail;
    logic [7:0]        ctrl1;
    logic [7:0]        ctrl2;
    logic              resetMask;
    logic              configured;
    logic              wrFlagTop;
    logic              wrFlagRail;
    logic              wrFault;

    assign wrFlagTop  = busReq.write && busReq.addr == ADDR_FLAG_TOP;
    assign wrFlagRail = busReq.write && busReq.addr == ADDR_FLAG_RAIL;
    assign wrFault    = busReq.write && busReq.addr == ADDR_FAULT;

    // self-clearing command bit
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            softReset <= 1'b0;
        end else begin
            softReset <= busReq.write && busReq.addr == ADDR_COMMAND
                && busReq.writeData[CMD_SW_RESET];
        end
    end

    // settings return to defaults on either reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            maskTop  <= MASK_TOP_RESET;
            maskRail <= MASK_RAIL_RESET;
            ctrl1    <= CTRL1_RESET;
            ctrl2    <= CTRL2_RESET;
        end else if (softReset) begin
            maskTop  <= MASK_TOP_RESET;
            maskRail <= MASK_RAIL_RESET;
            ctrl1    <= CTRL1_RESET;
            ctrl2    <= CTRL2_RESET;
        end else if (busReq.write) begin
            if (busReq.addr == ADDR_MASK_TOP) begin
                maskTop <= busReq.writeData;
            end else if (busReq.addr == ADDR_MASK_RAIL) begin
                maskRail <= busReq.writeData;
            end else if (busReq.addr == ADDR_POK_CTRL1) begin
                ctrl1 <= busReq.writeData;
            end else if (busReq.addr == ADDR_POK_CTRL2) begin
                ctrl2 <= busReq.writeData;
            end
        end
    end

    // reset mask comes from configuration only, writes ignored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resetMask  <= 1'b0;
            configured <= 1'b0;
        end else if (softReset) begin
            configured <= 1'b0;
        end else if (configDone) begin
            resetMask  <= configResetMask;
            configured <= 1'b1;
        end
    end

    // ==========================================================
    // rail qualification
    logic [RAILS-1:0] railOk;
    logic [RAILS-1:0] railOkPrev;
    logic [RAILS-1:0] watched;
    logic [RAILS-1:0] enablePrev;
    logic [RAILS-1:0] enableRise;
    logic [RAILS-1:0] windowSel;

    assign windowSel  = ctrl2[WINDOW_LSB +: RAILS];
    assign railOk     = monSync2.railValid
        & ~(windowSel & monSync2.railOver);
    assign railOkPrev = monPrev.railValid
        & ~(windowSel & monPrev.railOver);
    assign watched    = ctrl1[RAILS-1:0] & railEnable;
    assign enableRise = railEnable & ~enablePrev;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enablePrev <= '0;
        end else begin
            enablePrev <= railEnable;
        end
    end

    // ==========================================================
    // gated hold timer
    logic                  gatedMode;
    logic                  holdStart;
    logic                  holdBusy;
    logic [HOLD_WIDTH-1:0] holdCount;

    assign gatedMode = !ctrl2[CTL_MODE];
    assign holdStart = gatedMode && |(enableRise | voltageChange);
    assign holdBusy  = holdStart || holdCount != '0;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            holdCount <= '0;
        end else if (holdStart) begin
            holdCount <= HOLD_WIDTH'(HOLD_COUNT - 1);
        end else if (holdCount != '0) begin
            holdCount <= holdCount - 1'b1;
        end
    end

    // ==========================================================
    // flags
    logic             overheatFlag;
    logic             overvoltFlag;
    logic             powerOkFlag;
    logic             syncFlag;
    logic             measureFlag;
    logic             resetFlag;
    logic [RAILS-1:0] railFlag;
    logic [RAILS-1:0] fault;
    logic [RAILS-1:0] railRiseSet;
    logic [RAILS-1:0] railFallSet;
    logic [RAILS-1:0] faultSet;
    logic             powerOk;
    logic             powerOkDrop;
    logic             syncSet;

    assign railRiseSet = railOk & ~railOkPrev
        & ~maskRail[RAILS-1:0];
    assign railFallSet = ~railOk & railOkPrev
        & ~maskRail[FALL_LSB +: RAILS];
    // moving rails are not faults; gated mode waits out the hold
    assign faultSet = watched & ~railOk & ~railMoving
        & {RAILS{configured && !(gatedMode && holdBusy)}};
    assign syncSet = (monSync2.syncPresent ^ monPrev.syncPresent)
        || (clockDetectOn && !monSync2.syncPresent);

    sticky_flag u_overheat_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (monSync2.overheat),
        .clear    (wrFlagTop && busReq.writeData[TOP_OVERHEAT]),
        .hold     (monSync2.overheat),
        .wipe     (softReset),
        .flag     (overheatFlag)
    );

    sticky_flag u_overvolt_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (monSync2.overvoltage),
        .clear    (wrFlagTop && busReq.writeData[TOP_OVERVOLT]),
        .hold     (monSync2.overvoltage),
        .wipe     (softReset),
        .flag     (overvoltFlag)
    );

    sticky_flag u_power_ok_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (powerOkDrop && !maskTop[TOP_POWER_OK]),
        .clear    (wrFlagTop && busReq.writeData[TOP_POWER_OK]),
        .hold     (1'b0),
        .wipe     (softReset),
        .flag     (powerOkFlag)
    );

    sticky_flag u_sync_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (syncSet && !maskTop[TOP_SYNC]),
        .clear    (wrFlagTop && busReq.writeData[TOP_SYNC]),
        .hold     (1'b0),
        .wipe     (softReset),
        .flag     (syncFlag)
    );

    sticky_flag u_measure_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (measureDone && !maskTop[TOP_MEASURE]),
        .clear    (wrFlagTop && busReq.writeData[TOP_MEASURE]),
        .hold     (1'b0),
        .wipe     (softReset),
        .flag     (measureFlag)
    );

    // raised by lockout reset itself; mask applies at the output
    sticky_flag #(.INIT(1'b1)) u_reset_flag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .set      (softReset),
        .clear    (wrFlagTop && busReq.writeData[TOP_RESET]),
        .hold     (1'b0),
        .wipe     (1'b0),
        .flag     (resetFlag)
    );

    genvar r;
    generate
        for (r = 0; r < RAILS; r++) begin : g_rail
            sticky_flag u_rail_flag (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .set      (railRiseSet[r] || railFallSet[r]),
                .clear    (wrFlagRail && busReq.writeData[r]),
                .hold     (1'b0),
                .wipe     (softReset),
                .flag     (railFlag[r])
            );
            sticky_flag u_fault (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .set      (faultSet[r]),
                .clear    (wrFault && busReq.writeData[r]),
                .hold     (1'b0),
                .wipe     (softReset),
                .flag     (fault[r])
            );
        end
    endgenerate

    // ==========================================================
    // power-ok combine
    logic sourcesOk;
    logic railsOk;
    logic next_powerOk;

    assign powerOkDrop = powerOk && !next_powerOk;
    assign sourcesOk = !overheatFlag && !overvoltFlag
        && !(ctrl1[CTL_TWARN_SEL] && monSync2.thermalWarning);
    assign railsOk = &(~watched | (railOk & ~railMoving));

    always_comb begin
        next_powerOk = powerOk;
        if (!configured) begin
            next_powerOk = 1'b0;
        end else if (!sourcesOk) begin
            // protection events override the hold window
            next_powerOk = 1'b0;
        end else if (gatedMode) begin
            if (!holdBusy) begin
                next_powerOk = !(|fault);
            end
        end else begin
            next_powerOk = railsOk
                && !(|(enableRise & ctrl1[RAILS-1:0]))
                && !(ctrl2[CTL_GATING] && |fault);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            powerOk <= 1'b0;
        end else begin
            powerOk <= next_powerOk;
        end
    end

    // ==========================================================
    // pins
    logic pinLevel;
    logic pending;

    // polarity bit set means active-low pin
    assign pinLevel = next_powerOk ^ ctrl1[CTL_POLARITY];
    assign pending = overheatFlag || overvoltFlag || |railFlag
        || (powerOkFlag && !maskTop[TOP_POWER_OK])
        || (syncFlag && !maskTop[TOP_SYNC])
        || (measureFlag && !maskTop[TOP_MEASURE])
        || (resetFlag && !resetMask);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            powerOkOut <= 1'b0;
            powerOkOe  <= 1'b0;
        end else if (ctrl1[CTL_OPEN_DRAIN]) begin
            // open drain only pulls low
            powerOkOut <= 1'b0;
            powerOkOe  <= !pinLevel;
        end else begin
            powerOkOut <= pinLevel;
            powerOkOe  <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            interruptOut_n <= 1'b1;
        end else begin
            interruptOut_n <= !pending;
        end
    end

    // regulators stay off while a protection flag is pending
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regulatorShutdown <= 1'b1;
            generalOutputLow  <= 1'b1;
        end else begin
            regulatorShutdown <= monSync2.overheat || overheatFlag
                || monSync2.overvoltage || overvoltFlag
                || softReset;
            generalOutputLow  <= monSync2.overheat || overheatFlag
                || monSync2.overvoltage || overvoltFlag
                || softReset;
        end
    end

    // ==========================================================
    // register reads, data in the cycle after the strobe only
    logic [7:0] next_readData;

    always_comb begin
        next_readData = 8'h00;
        if (busReq.addr == ADDR_FLAG_TOP) begin
            next_readData = {2'b00, resetFlag, measureFlag, syncFlag,
                powerOkFlag, overvoltFlag, overheatFlag};
        end else if (busReq.addr == ADDR_FLAG_RAIL) begin
            next_readData = {4'h0, railFlag};
        end else if (busReq.addr == ADDR_MASK_TOP) begin
            next_readData = {2'b00, resetMask, maskTop[4:0]};
        end else if (busReq.addr == ADDR_MASK_RAIL) begin
            next_readData = maskRail;
        end else if (busReq.addr == ADDR_STATUS) begin
            next_readData = {railOk, monSync2.syncPresent,
                powerOk, monSync2.overvoltage,
                monSync2.overheat};
        end else if (busReq.addr == ADDR_POK_CTRL1) begin
            next_readData = ctrl1;
        end else if (busReq.addr == ADDR_POK_CTRL2) begin
            next_readData = ctrl2;
        end else if (busReq.addr == ADDR_FAULT) begin
            next_readData = {4'h0, fault};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            readData <= 8'h00;
        end else if (busReq.read) begin
            readData <= next_readData;
        end else begin
            readData <= 8'h00;
        end
    end
endmodule : power_ok_flags

// ---- verification/power_ok_flags_asserts.sv ----
// port checker for the power-ok and event flag block
// assumes it is bound to power_ok_flags on core_clk
`timescale 1ns/1ps
module power_ok_flags_asserts (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      reset_n,
    // watched ports
    input wire power_ok_pkg::bus_req_type busReq,
    input wire logic [7:0]                readData,
    input wire power_ok_pkg::monitor_type monitor,
    input wire logic                      interruptOut_n,
    input wire logic                      regulatorShutdown,
    input wire logic                      generalOutputLow
);
    import power_ok_pkg::*;
    // ====
    // sequences
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // five cycles covers the two-stage sync plus the flag register
    sequence hot_s; monitor.overheat [*5]; endsequence
    sequence surge_s; monitor.overvoltage [*5]; endsequence
    sequence cmd_s;
        busReq.write && busReq.addr == ADDR_COMMAND && busReq.writeData[0];
    endsequence
    // ====
    // properties
    chk_read_quiet: assert property (
        !$past(busReq.read) |-> readData == 8'h00)
        else $error("read data outside its answer cycle");
    chk_unmapped_zero: assert property (
        busReq.read && busReq.addr > ADDR_FAULT |=> readData == 8'h00)
        else $error("unmapped read not zero");
    chk_heat_stop: assert property (
        hot_s |-> regulatorShutdown && generalOutputLow)
        else $error("overheat did not stop regulators");
    chk_surge_stop: assert property (
        surge_s |-> regulatorShutdown && generalOutputLow)
        else $error("overvoltage did not stop regulators");
    chk_heat_irq: assert property (
        hot_s ##1 monitor.overheat |-> !interruptOut_n)
        else $error("overheat left interrupt released");
    chk_reset_stop: assert property (
        cmd_s |-> ##[1:3] regulatorShutdown)
        else $error("software reset did not shut down");
    chk_reset_irq: assert property (
        cmd_s |-> ##[2:6] !interruptOut_n)
        else $error("software reset flag not signalled");
    chk_irq_release: assert property (
        $rose(interruptOut_n) |-> $past(busReq.write)
        || $past(busReq.write, 2) || $past(busReq.write, 3))
        else $error("interrupt released without a clear");
endmodule : power_ok_flags_asserts

// ---- verification/host_model.sv ----
// host processor on the register port
// assumes read data stand in the cycle after the read strobe
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic                 core_clk,
    // register port
    output power_ok_pkg::bus_req_type busReq,
    input wire logic [7:0]           readData
);
    import power_ok_pkg::*;
    // ====
    // bus cycles
    initial busReq = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, writeData: d, write: 1'b1, read: 1'b0};
        @(posedge core_clk);
        busReq.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, writeData: 8'h00, write: 1'b0, read: 1'b1};
        @(posedge core_clk);
        busReq.read <= 1'b0;
        // sampled before this edge's update lands
        @(posedge core_clk);
        d = readData;
    endtask : rd
endmodule : host_model

// ---- verification/power_ok_flags_bench.sv ----
// self-checking bench for the power-ok and event flag block
// assumes host_model drives the register port
`timescale 1ns/1ps
module power_ok_flags_bench;
    import power_ok_pkg::*;
    // ====
    // signals
    localparam int unsigned HOLD = 20;
    logic             core_clk      = 1'b0, reset_n = 1'b0;
    bus_req_type      busReq;
    logic [7:0]       readData, d;
    monitor_type      monitor       = '0;
    logic [RAILS-1:0] railEnable    = '0;
    logic [RAILS-1:0] voltageChange = '0, railMoving = '0;
    logic             clockDetectOn = 1'b0;
    logic             measureDone   = 1'b0, configDone = 1'b0;
    logic             interruptOut_n, powerOkOut, powerOkOe;
    logic             regulatorShutdown, generalOutputLow;
    int               mismatches = 0, cmp_count = 0, cycles = 0;
    always #5 core_clk = ~core_clk;
    power_ok_flags #(.HOLD_COUNT(HOLD)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
        .readData(readData), .monitor(monitor), .railEnable(railEnable),
        .railMoving(railMoving), .voltageChange(voltageChange),
        .clockDetectOn(clockDetectOn), .measureDone(measureDone),
        .configDone(configDone), .configResetMask(1'b0),
        .interruptOut_n(interruptOut_n), .powerOkOut(powerOkOut),
        .powerOkOe(powerOkOe), .regulatorShutdown(regulatorShutdown),
        .generalOutputLow(generalOutputLow));
    host_model i_host (.core_clk(core_clk), .busReq(busReq),
        .readData(readData));
    // ====
    // helpers
    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // hang guard, tests need well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            complete_run;
        end
    end
    task automatic check(input string n, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic rdchk(input logic [7:0] a, exp);
        i_host.rd(a, d);
        check($sformatf("register %h", a), d, exp);
    endtask : rdchk
    task automatic pok(input logic exp);
        i_host.rd(ADDR_STATUS, d);
        check("power ok state", {7'h00, d[TOP_POWER_OK]}, {7'h00, exp});
    endtask : pok
    task automatic hazard(input int b, input logic v);
        if (b == TOP_OVERHEAT) monitor.overheat <= v;
        else monitor.overvoltage <= v;
    endtask : hazard
    task automatic pulse(input logic cfg);
        if (cfg) configDone <= 1'b1;
        else measureDone <= 1'b1;
        tick(1);
        configDone <= 1'b0;
        measureDone <= 1'b0;
        tick(3);
    endtask : pulse
    // ====
    // scenarios
    task automatic t_reset;
        check("interrupt", {7'h00, interruptOut_n}, 8'h00);
        rdchk(ADDR_FLAG_TOP, 8'h20);
        rdchk(ADDR_POK_CTRL1, CTRL1_RESET);
        rdchk(ADDR_POK_CTRL2, CTRL2_RESET);
        rdchk(ADDR_MASK_RAIL, MASK_RAIL_RESET);
        rdchk(8'h3C, 8'h00);
        i_host.wr(ADDR_FLAG_TOP, 8'h20);
        tick(2);
        check("interrupt", {7'h00, interruptOut_n}, 8'h01);
        $display("test reset done");
    endtask : t_reset
    task automatic t_protect;
        for (int b = 0; b < 2; b++) begin
            hazard(b, 1'b1);
            tick(6);
            check("stop", {6'h00, regulatorShutdown, generalOutputLow},
                8'h03);
            i_host.wr(ADDR_FLAG_TOP, 8'h01 << b);
            rdchk(ADDR_FLAG_TOP, 8'h01 << b);
            rdchk(ADDR_STATUS, 8'h01 << b);
            hazard(b, 1'b0);
            tick(4);
            i_host.wr(ADDR_FLAG_TOP, 8'h01 << b);
            rdchk(ADDR_FLAG_TOP, 8'h00);
        end
        $display("test protect done");
    endtask : t_protect
    task automatic t_events;
        pulse(1'b0);
        rdchk(ADDR_FLAG_TOP, 8'h10);
        i_host.wr(ADDR_FLAG_TOP, 8'h10);
        i_host.wr(ADDR_MASK_TOP, 8'h10);
        pulse(1'b0);
        rdchk(ADDR_FLAG_TOP, 8'h00);
        monitor.syncPresent <= 1'b1;
        tick(5);
        rdchk(ADDR_FLAG_TOP, 8'h08);
        i_host.wr(ADDR_FLAG_TOP, 8'h08);
        clockDetectOn <= 1'b1;
        monitor.syncPresent <= 1'b0;
        tick(5);
        rdchk(ADDR_FLAG_TOP, 8'h08);
        rdchk(ADDR_STATUS, 8'h00);
        clockDetectOn <= 1'b0;
        i_host.wr(ADDR_FLAG_TOP, 8'h08);
        $display("test events done");
    endtask : t_events
    task automatic t_rails;
        monitor.railValid <= 4'hF;
        tick(5);
        rdchk(ADDR_FLAG_RAIL, 8'h0F);
        rdchk(ADDR_STATUS, 8'hF0);
        i_host.wr(ADDR_MASK_RAIL, 8'hF0);
        i_host.wr(ADDR_FLAG_RAIL, 8'h0F);
        monitor.railValid <= 4'h0;
        tick(5);
        rdchk(ADDR_FLAG_RAIL, 8'h00);
        monitor.railValid <= 4'hF;
        monitor.railOver <= 4'hF;
        i_host.wr(ADDR_POK_CTRL2, 8'h3C);
        tick(4);
        rdchk(ADDR_STATUS, 8'h00);
        i_host.wr(ADDR_POK_CTRL2, 8'h00);
        monitor.railOver <= 4'h0;
        $display("test rails done");
    endtask : t_rails
    task automatic t_continuous;
        i_host.wr(ADDR_POK_CTRL2, 8'h01);
        pulse(1'b1);
        check("pin", {6'h00, powerOkOe, powerOkOut}, 8'h03);
        i_host.wr(ADDR_POK_CTRL1, 8'h1F);
        tick(3);
        check("pin", {6'h00, powerOkOe, powerOkOut}, 8'h02);
        pok(1'b1);
        i_host.rd(ADDR_FLAG_TOP, d);
        check("change flag", d & 8'h04, 8'h00);
        railEnable <= 4'h1;
        monitor.railValid <= 4'hD;
        tick(5);
        pok(1'b1);
        monitor.railValid <= 4'hC;
        tick(5);
        pok(1'b0);
        rdchk(ADDR_FAULT, 8'h01);
        i_host.rd(ADDR_FLAG_TOP, d);
        check("change flag", d & 8'h04, 8'h04);
        monitor.railValid <= 4'hF;
        tick(5);
        pok(1'b1);
        railMoving <= 4'h1;
        pok(1'b0);
        railMoving <= 4'h0;
        i_host.wr(ADDR_POK_CTRL2, 8'h03);
        tick(3);
        pok(1'b0);
        i_host.wr(ADDR_FAULT, 8'h01);
        tick(3);
        pok(1'b1);
        $display("test continuous done");
    endtask : t_continuous
    task automatic t_soft;
        i_host.wr(ADDR_COMMAND, 8'h01);
        tick(3);
        rdchk(ADDR_POK_CTRL2, CTRL2_RESET);
        rdchk(ADDR_MASK_TOP, 8'h00);
        i_host.rd(ADDR_FLAG_TOP, d);
        check("reset flag", d & 8'h20, 8'h20);
        pulse(1'b1);
        pok(1'b1);
        monitor.railValid <= 4'hE;
        voltageChange <= 4'h1;
        tick(1);
        voltageChange <= 4'h0;
        tick(HOLD - 8);
        pok(1'b1);
        tick(10);
        pok(1'b0);
        $display("test soft reset done");
    endtask : t_soft
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        tick(2);
        t_reset;
        t_protect;
        t_events;
        t_rails;
        t_continuous;
        t_soft;
        complete_run;
    end
endmodule : power_ok_flags_bench
bind power_ok_flags power_ok_flags_asserts i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .busReq(busReq),
    .readData(readData), .monitor(monitor),
    .interruptOut_n(interruptOut_n),
    .regulatorShutdown(regulatorShutdown),
    .generalOutputLow(generalOutputLow));
